// ### hdl/rtm_map.vh
// Register offsets, field positions, reset values and timing counts for the rollover timer
`ifndef RTM_MAP_VH
`define RTM_MAP_VH

`define RTM_ADR_CFG        8'h00
`define RTM_ADR_COUNT      8'h04
`define RTM_ADR_WDOG       8'h08
`define RTM_ADR_STATUS     8'h0C
`define RTM_ADR_MASK       8'h10

`define RTM_CFG_RATE_LO    0
`define RTM_CFG_RATE_HI    2
`define RTM_CFG_ASSIGN     3
`define RTM_CFG_EDGE       4
`define RTM_CFG_SOURCE     5
`define RTM_CFG_WRAP_IE    6
`define RTM_CFG_RST        8'h00

`define RTM_ST_WDOG        0
`define RTM_ST_EDGE        1
`define RTM_ST_W           2

`define RTM_WDOG_DIV       16

`endif

// ### hdl/rtm_edge.v
// Synchroniser and selectable edge detector for the external timer input
`timescale 1ns/1ns
module rtm_edge (
  input  wire clk,
  input  wire srst,
  input  wire pin,
  input  wire falling,
  output wire edge_pulse
);
  reg sync1_q;
  reg sync2_q;
  reg prev_q;

  // First stage feeds only the second one
  always @(posedge clk) begin
    if (srst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // One pulse per qualifying transition
  assign edge_pulse = falling ? (prev_q & ~sync2_q) : (~prev_q & sync2_q);
endmodule

// ### hdl/rtm_scaler.v
// Shared 8-bit scaler with power-of-two divide ratio
`timescale 1ns/1ns
module rtm_scaler #(
  parameter WIDTH = 8
) (
  input  wire       clk,
  input  wire       srst,
  input  wire       clear,
  input  wire       en,
  input  wire [2:0] rate,
  output wire       tick
);
  reg  [WIDTH-1:0] cnt_q;
  wire [WIDTH-1:0] mask;

  function [WIDTH-1:0] rate_mask;
    input [2:0] r;
    begin
      rate_mask = {{(WIDTH-1){1'b0}}, 1'b1} << r;
      rate_mask = rate_mask | (rate_mask - {{(WIDTH-1){1'b0}}, 1'b1});
    end
  endfunction

  // Ratio 1:2 at rate 0 up to 1:256 at rate 7
  assign mask = rate_mask(rate);
  assign tick = en & ((cnt_q & mask) == mask);

  always @(posedge clk) begin
    if (srst || clear) begin
      cnt_q <= {WIDTH{1'b0}};
    end else if (en) begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ### hdl/rtm_top.v
// Rollover timer with shared scaler, watchdog counter and Wishbone registers
// Notes on behaviour
// - Eight-bit counter, internal or external steps
// - Source bit zero selects instruction clock
// - Internal mode steps each cycle unless scaled
// - Source bit one counts external input edges
// - Edge bit one falling, zero rising
// - Wrap from maximum to zero raises interrupt
// - No pending flag for counter wrap
// - Eight-bit scaler extends count to sixteen bits
// - Unassigned scaler divides counter steps
// - Separate eight-bit watchdog counter shares scaler
// - Assign bit set gives scaler to watchdog
// - Three rate bits pick divide ratio
// - Scaler serves one counter at a time; count hidden from software
// - Wrap interrupt gated by enable bit
`timescale 1ns/1ns
`include "rtm_map.vh"
module rtm_top #(
  parameter WDOG_DIV = `RTM_WDOG_DIV
) (
  input  wire        CORE_CLK,
  input  wire        SRST,
  input  wire [7:0]  WB_ADR_I,
  input  wire [31:0] WB_DAT_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire        WB_WE_I,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        EXT_TIMER_IN,
  output reg         WRAP_IRQ,
  output reg         IRQ
);
  reg  [7:0]             cfg_q;
  reg  [7:0]             cfg_d;
  reg  [7:0]             count_q;
  reg  [7:0]             count_d;
  reg  [7:0]             wdog_q;
  reg  [7:0]             wdog_d;
  reg  [15:0]            wdiv_q;
  reg  [15:0]            wdiv_d;
  reg  [`RTM_ST_W-1:0]   status_q;
  reg  [`RTM_ST_W-1:0]   status_d;
  reg  [`RTM_ST_W-1:0]   mask_q;
  reg  [`RTM_ST_W-1:0]   mask_d;
  reg                    assign_prev_q;
  reg                    wrap_d;
  reg                    irq_d;
  reg                    ack_d;
  reg  [31:0]            rdata;

  wire                   req;
  wire                   wr_fire;
  wire                   lane0;
  wire                   ext_edge;
  wire                   wdog_en;
  wire                   wdog_ovf;
  wire                   to_wdog;
  wire                   scaler_en;
  wire                   scaler_clr;
  wire                   scaler_tick;
  wire                   base_step;
  wire                   count_step;
  wire                   wdog_event;
  wire                   wr_cfg;
  wire                   wr_count;
  wire                   wr_wdog;
  wire                   wr_status;
  wire                   wr_mask;

  // Divider compare value; the subtraction runs at 32 bits and is cut on purpose
  localparam [31:0] WDIV_FULL = WDOG_DIV - 1;
  localparam [15:0] WDIV_LAST = WDIV_FULL[15:0];

  // One register write strobe: qualified request at the acknowledge edge, exact offset
  function wr_hit;
    input       fire;
    input [7:0] adr;
    input [7:0] target;
    begin
      wr_hit = fire & (adr == target);
    end
  endfunction

  // Bus request and write qualified at the acknowledge edge
  assign req     = WB_CYC_I & WB_STB_I;
  assign wr_fire = req & WB_WE_I & WB_ACK_O;
  assign lane0   = WB_SEL_I[0];

  // Writes with lane 0 off are acknowledged and dropped
  assign wr_cfg    = wr_hit(wr_fire & lane0, WB_ADR_I, `RTM_ADR_CFG);
  assign wr_count  = wr_hit(wr_fire & lane0, WB_ADR_I, `RTM_ADR_COUNT);
  assign wr_wdog   = wr_hit(wr_fire & lane0, WB_ADR_I, `RTM_ADR_WDOG);
  assign wr_status = wr_hit(wr_fire & lane0, WB_ADR_I, `RTM_ADR_STATUS);
  assign wr_mask   = wr_hit(wr_fire & lane0, WB_ADR_I, `RTM_ADR_MASK);

  rtm_edge u_edge (
    .clk        (CORE_CLK),
    .srst       (SRST),
    .pin        (EXT_TIMER_IN),
    .falling    (cfg_q[`RTM_CFG_EDGE]),
    .edge_pulse (ext_edge)
  );

  // Watchdog runs from its own slow enable, not the instruction clock
  assign wdog_en  = (wdiv_q == WDIV_LAST);
  assign wdog_ovf = wdog_en & (wdog_q == 8'hFF);

  // One mux feeds the scaler, so it belongs to one counter only
  assign to_wdog    = cfg_q[`RTM_CFG_ASSIGN];
  assign base_step  = cfg_q[`RTM_CFG_SOURCE] ? ext_edge : 1'b1;
  assign scaler_en  = to_wdog ? wdog_ovf : base_step;
  // Any load of either counter restarts the scaler, so no stale phase carries over
  assign scaler_clr = (to_wdog != assign_prev_q) | wr_count | wr_wdog;

  rtm_scaler #(
    .WIDTH (8)
  ) u_scaler (
    .clk   (CORE_CLK),
    .srst  (SRST),
    .clear (scaler_clr),
    .en    (scaler_en),
    .rate  (cfg_q[`RTM_CFG_RATE_HI:`RTM_CFG_RATE_LO]),
    .tick  (scaler_tick)
  );

  assign count_step = to_wdog ? base_step : scaler_tick;
  assign wdog_event = to_wdog ? scaler_tick : wdog_ovf;

  always @(posedge CORE_CLK) begin
    if (SRST) begin
      assign_prev_q <= 1'b0;
    end else begin
      assign_prev_q <= to_wdog;
    end
  end

  // Configuration register, byte lane 0
  always @* begin
    cfg_d = cfg_q;
    if (wr_cfg) begin
      cfg_d = WB_DAT_I[7:0];
    end
  end

  always @(posedge CORE_CLK) begin
    if (SRST) begin
      cfg_q <= `RTM_CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Free-running counter; a software load wins over a step
  // A load lands at the acknowledge edge, the same edge a step would
  always @* begin
    count_d = count_q;
    if (wr_count) begin
      count_d = WB_DAT_I[7:0];
    end else if (count_step) begin
      count_d = count_q + 8'h01;
    end
  end

  always @(posedge CORE_CLK) begin
    if (SRST) begin
      count_q <= 8'h00;
    end else begin
      count_q <= count_d;
    end
  end

  // Wrap pulse is gated and never latched, so software must poll the count
  always @* begin
    wrap_d = count_step & (count_q == 8'hFF) & cfg_q[`RTM_CFG_WRAP_IE];
    if (wr_count) begin
      wrap_d = 1'b0;
    end
  end

  always @(posedge CORE_CLK) begin
    if (SRST) begin
      WRAP_IRQ <= 1'b0;
    end else begin
      WRAP_IRQ <= wrap_d;
    end
  end

  // Watchdog counter and its divider; any write to it restarts it
  // Divider and counter restart together, so the first step comes a full period later
  always @* begin
    wdiv_d = wdiv_q + 16'h0001;
    wdog_d = wdog_q;
    if (wr_wdog) begin
      wdiv_d = 16'h0000;
      wdog_d = 8'h00;
    end else if (wdog_en) begin
      wdiv_d = 16'h0000;
      wdog_d = wdog_q + 8'h01;
    end
  end

  always @(posedge CORE_CLK) begin
    if (SRST) begin
      wdiv_q <= 16'h0000;
      wdog_q <= 8'h00;
    end else begin
      wdiv_q <= wdiv_d;
      wdog_q <= wdog_d;
    end
  end

  // Sticky status: hardware set wins over a write-one clear
  always @* begin
    status_d = status_q;
    if (wr_status) begin
      status_d = status_q & ~WB_DAT_I[`RTM_ST_W-1:0];
    end
    if (wdog_event) begin
      status_d[`RTM_ST_WDOG] = 1'b1;
    end
    if (ext_edge) begin
      status_d[`RTM_ST_EDGE] = 1'b1;
    end
  end

  // New mask applies in the same cycle as the write that brings it
  always @* begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = WB_DAT_I[`RTM_ST_W-1:0];
    end
    irq_d = |(status_d & mask_d);
  end

  always @(posedge CORE_CLK) begin
    if (SRST) begin
      status_q <= {`RTM_ST_W{1'b0}};
      mask_q   <= {`RTM_ST_W{1'b0}};
      IRQ      <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      IRQ      <= irq_d;
    end
  end

  // Read mux; unmapped offsets read zero. The scaler count is not mapped.
  always @* begin
    rdata = 32'h0000_0000;
    case (WB_ADR_I)
      `RTM_ADR_CFG:    rdata[7:0] = cfg_q;
      `RTM_ADR_COUNT:  rdata[7:0] = count_q;
      `RTM_ADR_WDOG:   rdata[7:0] = wdog_q;
      `RTM_ADR_STATUS: rdata[`RTM_ST_W-1:0] = status_q;
      `RTM_ADR_MASK:   rdata[`RTM_ST_W-1:0] = mask_q;
      default:         rdata = 32'h0000_0000;
    endcase
  end

  // One-wait-state slave: ack one cycle after the request, for one cycle
  always @* begin
    ack_d = req & ~WB_ACK_O;
  end

  always @(posedge CORE_CLK) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= ack_d;
      if (ack_d) begin
        WB_DAT_O <= rdata; // Held until the next request, not only while ack stands
      end
    end
  end
endmodule

// ### tb/rtm_chk.sv
// Port checker for the rollover timer
`timescale 1ns/1ns
module rtm_chk (
  input wire logic        CORE_CLK,
  input wire logic        SRST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        WRAP_IRQ,
  input wire logic        IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  a_ack_one_wait: assert property (s_req |=> s_ack) else $error("ack not after one wait");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_rdat_hold: assert property (!$rose(WB_ACK_O) |-> $stable(WB_DAT_O))
    else $error("read data moved");
  a_wrap_single:
    assert property (WRAP_IRQ |=> !WRAP_IRQ) else $error("wrap pulse too long");
  a_reset_quiet:
    assert property (disable iff (1'b0) SRST |=> !WRAP_IRQ && !IRQ && !WB_ACK_O)
    else $error("outputs live in reset");
  a_start_calm:
    assert property ($fell(SRST) |-> !WRAP_IRQ [*8]) else $error("wrap soon after reset");
  a_irq_calm:
    assert property ($fell(SRST) |-> !IRQ [*2]) else $error("irq soon after reset");
endmodule
bind rtm_top rtm_chk i_rtm_chk (.CORE_CLK, .SRST, .WB_CYC_I, .WB_STB_I, .WB_DAT_O,
  .WB_ACK_O, .WRAP_IRQ, .IRQ);

// ### tb/rtm_src.sv
// Source model driving the external timer input
`timescale 1ns/1ns
module rtm_src (
  input  wire logic clk,
  output logic      pin = 1'b0
);
  // Four cycles per level, well above what the input sync needs
  task automatic burst(input int n);
    repeat (n) begin
      pin <= ~pin;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// ### tb/rtm_tb.sv
// Self-checking bench for the rollover timer
`timescale 1ns/1ns
`include "rtm_map.vh"
module tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic [31:0] rdat, q;
  logic        ack, wrap, irq, pin;
  int          n_errors = 0;
  int          samples_checked = 0;
  always #4 clk = ~clk;
  rtm_top #(.WDOG_DIV(2)) i_rtm_top (.CORE_CLK(clk), .SRST(srst), .WB_ADR_I(adr),
    .WB_DAT_I(dat), .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .EXT_TIMER_IN(pin), .WRAP_IRQ(wrap), .IRQ(irq));
  rtm_src i_rtm_src (.clk(clk), .pin(pin));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    chk("ack", ack, 1);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic t_reset;
    wb(0, `RTM_ADR_CFG, 0);
    chk("cfg", q, 0);
    wb(0, 8'h20, 0);
    chk("hole", q, 0);
    wb(1, `RTM_ADR_CFG, 8'h4A);
    wb(0, `RTM_ADR_CFG, 0);
    chk("cfg rw", q, 32'h4A);
  endtask
  // Span of 64 cycles is a multiple of every ratio used, so scaler phase drops out
  task automatic t_rate(input logic [7:0] a, input logic [7:0] c, input logic [7:0] e);
    logic [7:0] v, d;
    wb(1, `RTM_ADR_CFG, c);
    wb(0, a, 0);
    v = q[7:0];
    repeat (61) @(posedge clk);
    wb(0, a, 0);
    d = q[7:0] - v;
    chk("steps", d, e);
  endtask
  task automatic t_ext(input logic [7:0] c, input int n, input logic [7:0] e);
    logic [7:0] v, d;
    wb(1, `RTM_ADR_CFG, c);
    wb(1, `RTM_ADR_STATUS, 8'h03);
    wb(0, `RTM_ADR_COUNT, 0);
    v = q[7:0];
    i_rtm_src.burst(n);
    wb(0, `RTM_ADR_COUNT, 0);
    d = q[7:0] - v;
    chk("edges", d, e);
    wb(1, `RTM_ADR_MASK, 8'h00);
    chk("irq masked", irq, 0);
    wb(1, `RTM_ADR_MASK, 8'h02);
    chk("irq", irq, 1);
    wb(1, `RTM_ADR_STATUS, 8'h02);
    chk("irq cleared", irq, 0);
  endtask
  task automatic t_wrap(input logic [7:0] c, input logic e);
    logic seen;
    seen = 1'b0;
    wb(1, `RTM_ADR_CFG, c);
    wb(1, `RTM_ADR_COUNT, 8'hF0);
    repeat (40) begin
      @(posedge clk);
      seen |= wrap;
    end
    chk("wrap", seen, e);
  endtask
  // Overflow lands in status bit 0 after 256 watchdog steps, or after 512 when postscaled
  task automatic t_post(input logic [7:0] c, input logic e1, input logic e2);
    wb(1, `RTM_ADR_CFG, c);
    wb(1, `RTM_ADR_WDOG, 0);
    wb(1, `RTM_ADR_STATUS, 8'h03);
    repeat (600) @(posedge clk);
    wb(0, `RTM_ADR_STATUS, 0);
    chk("wdog event", q[0], e1);
    repeat (500) @(posedge clk);
    wb(0, `RTM_ADR_STATUS, 0);
    chk("postscaled", q[0], e2);
  endtask
  task automatic wrap_up;
    $display("Checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_rate(`RTM_ADR_COUNT, 8'h08, 8'd64);
    for (int i = 0; i < 6; i++)
      t_rate(`RTM_ADR_COUNT, 8'(i), 8'(32 >> i));
    t_rate(`RTM_ADR_WDOG, 8'h08, 8'd32);
    t_ext(8'h28, 3, 8'd2);
    t_ext(8'h38, 5, 8'd3);
    t_wrap(8'h48, 1'b1);
    t_wrap(8'h08, 1'b0);
    t_post(8'h00, 1'b1, 1'b1);
    t_post(8'h08, 1'b0, 1'b1);
    wrap_up;
  end
  initial begin
    #100000;
    n_errors++;
    wrap_up;
  end
endmodule
